// ### hw/ladder_edge_compare_exec.sv
// Contract
// - falling-edge parallel contact ORs in a term true only on on-to-off scan.
// - rising pulse output sets its bit for one scan on off-to-on drive.
// - falling pulse output sets its bit for one scan on on-to-off drive.
// - scan runs from address 0 to end instruction, then restarts at 0.
// - compare result covers three consecutive bit devices from the given one.
// - compare operands are two's complement; bit 15 or bit 31 is sign.
// - driven compare turns exactly one of three result bits on.
// - undriven compare is not evaluated; result bits keep their state.
// - result bits persist until explicitly cleared; disabling never clears.
// - zone result is three consecutive bits, exactly one on when driven.
// - zone bits mean below, inside inclusive, above.
// - lower bound above upper bound makes lower bound both bounds.
// - undriven zone compare is not evaluated; result bits keep their state.
// - driven copy moves source to destination; undriven leaves it alone.
`timescale 1ns/1ps
`default_nettype none
module ladder_edge_compare_exec (
  input  wire  logic                   clock,
  input  wire  logic                   resetn,
  input  wire  logic                   exec_valid,
  input  wire  ladder_pkg::op_t        exec_op,
  input  wire  logic                   exec_pulse,
  input  wire  logic                   exec_wide,
  input  wire  logic                   drive_in,
  input  wire  logic                   contact_in,
  input  wire  logic [5:0]             edge_slot,
  input  wire  logic [7:0]             dest_dev,
  input  wire  logic [31:0]            val_a,
  input  wire  logic [31:0]            val_b,
  input  wire  logic [31:0]            val_c,
  output logic                         logic_result,
  output logic                         bit_wr,
  output logic [7:0]                   bit_addr,
  output logic [1:0]                   bit_count,
  output logic [2:0]                   bit_val,
  output logic                         word_wr,
  output logic [7:0]                   word_addr,
  output logic [31:0]                  word_data,
  output logic [15:0]                  prog_addr,
  output logic                         scan_wrap
);

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic                  hist;
  logic                  rise;
  logic                  fall;
  logic                  contact_fall;
  logic                  fire;
  logic                  is_app;

  logic [ladder_pkg::SLOTS-1:0] hist_q;
  logic                  logic_q;
  logic                  bit_wr_q;
  logic [7:0]            bit_addr_q;
  logic [1:0]            bit_count_q;
  logic [2:0]            bit_val_q;
  logic                  word_wr_q;
  logic [7:0]            word_addr_q;
  logic [31:0]           word_data_q;
  logic [15:0]           pc_q;
  logic [15:0]           pc_d;
  logic                  wrap_q;

  cmp_if cif ();

  assign cif.wide  = exec_wide;
  assign cif.val_a = val_a;
  assign cif.val_b = val_b;
  assign cif.val_c = val_c;

  compare_unit u_cmp (
    .cif (cif.unit)
  );

  always_comb begin
    hist = hist_q[edge_slot];
    rise = drive_in & ~hist;
    fall = hist & ~drive_in;
    contact_fall = hist & ~contact_in;
    is_app = (exec_op == ladder_pkg::OP_COMPARE) ||
             (exec_op == ladder_pkg::OP_ZONE) ||
             (exec_op == ladder_pkg::OP_COPY);
    // pulse forms act once per rising drive, plain forms on every driven scan
    fire = exec_valid & is_app & drive_in & (~exec_pulse | rise);
  end

  // ----------------------------------------------------------------
  // edge history, one bit per edge instruction
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      hist_q <= '0;
    end else if (exec_valid) begin
      if (exec_op == ladder_pkg::OP_OR_FALL) begin
        hist_q[edge_slot] <= contact_in;
      end else if ((exec_op == ladder_pkg::OP_RISE_PULSE) ||
                   (exec_op == ladder_pkg::OP_FALL_PULSE) ||
                   (is_app && exec_pulse)) begin
        hist_q[edge_slot] <= drive_in;
      end
    end
  end

  // ----------------------------------------------------------------
  // logic result
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      logic_q <= 1'b0;
    end else if (exec_valid) begin
      if (exec_op == ladder_pkg::OP_OR_FALL) begin
        logic_q <= drive_in | contact_fall;
      end else begin
        logic_q <= drive_in;
      end
    end
  end

  // ----------------------------------------------------------------
  // bit device writes
  // ----------------------------------------------------------------
  // the pulse bit is rewritten every scan, so it is on for exactly one scan
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      bit_wr_q    <= 1'b0;
      bit_addr_q  <= 8'h00;
      bit_count_q <= 2'h0;
      bit_val_q   <= 3'h0;
    end else begin
      bit_wr_q <= 1'b0;
      if (exec_valid) begin
        unique case (exec_op)
          ladder_pkg::OP_RISE_PULSE: begin
            bit_wr_q    <= 1'b1;
            bit_addr_q  <= dest_dev;
            bit_count_q <= ladder_pkg::CNT_ONE;
            bit_val_q   <= {2'h0, rise};
          end
          ladder_pkg::OP_FALL_PULSE: begin
            bit_wr_q    <= 1'b1;
            bit_addr_q  <= dest_dev;
            bit_count_q <= ladder_pkg::CNT_ONE;
            bit_val_q   <= {2'h0, fall};
          end
          ladder_pkg::OP_COMPARE: begin
            // no write when idle, so results stay until cleared elsewhere
            bit_wr_q <= fire;
            if (fire) begin
              bit_addr_q  <= dest_dev;
              bit_count_q <= ladder_pkg::CNT_TRIPLE;
              bit_val_q   <= cif.cmp_res;
            end
          end
          ladder_pkg::OP_ZONE: begin
            bit_wr_q <= fire;
            if (fire) begin
              bit_addr_q  <= dest_dev;
              bit_count_q <= ladder_pkg::CNT_TRIPLE;
              bit_val_q   <= cif.zone_res;
            end
          end
          ladder_pkg::OP_IDLE, ladder_pkg::OP_OR_FALL,
          ladder_pkg::OP_COPY, ladder_pkg::OP_END: begin
            bit_count_q <= bit_count_q;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // word copy
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      word_wr_q   <= 1'b0;
      word_addr_q <= 8'h00;
      word_data_q <= 32'h0000_0000;
    end else begin
      word_wr_q <= fire && (exec_op == ladder_pkg::OP_COPY);
      if (fire && (exec_op == ladder_pkg::OP_COPY)) begin
        word_addr_q <= dest_dev;
        word_data_q <= val_a;
      end
    end
  end

  // ----------------------------------------------------------------
  // program position and scan wrap
  // ----------------------------------------------------------------
  always_comb begin
    pc_d = pc_q + {12'h000, ladder_pkg::step_len(exec_op)};
    if (exec_op == ladder_pkg::OP_END) begin
      pc_d = ladder_pkg::PC_START;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pc_q   <= ladder_pkg::PC_START;
      wrap_q <= 1'b0;
    end else begin
      wrap_q <= exec_valid && (exec_op == ladder_pkg::OP_END);
      if (exec_valid) begin
        pc_q <= pc_d;
      end
    end
  end

  assign logic_result = logic_q;
  assign bit_wr       = bit_wr_q;
  assign bit_addr     = bit_addr_q;
  assign bit_count    = bit_count_q;
  assign bit_val      = bit_val_q;
  assign word_wr      = word_wr_q;
  assign word_addr    = word_addr_q;
  assign word_data    = word_data_q;
  assign prog_addr    = pc_q;
  assign scan_wrap    = wrap_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic a_neg;
  logic b_neg;
  logic bounds_swapped;

  always_comb begin
    a_neg = exec_wide ? val_a[ladder_pkg::SIGN_WIDE] : val_a[ladder_pkg::SIGN_NARROW];
    b_neg = exec_wide ? val_b[ladder_pkg::SIGN_WIDE] : val_b[ladder_pkg::SIGN_NARROW];
    bounds_swapped = ladder_pkg::widen(val_a, exec_wide) >
                     ladder_pkg::widen(val_b, exec_wide);
  end

  sequence cmp_driven;
    exec_valid && (exec_op == ladder_pkg::OP_COMPARE) && fire;
  endsequence

  sequence zone_driven;
    exec_valid && (exec_op == ladder_pkg::OP_ZONE) && fire;
  endsequence

  sequence pulse_rise_seen;
    exec_valid && (exec_op == ladder_pkg::OP_RISE_PULSE);
  endsequence

  or_fall_term_a: assert property (@(posedge clock) disable iff (!resetn)
    exec_valid && (exec_op == ladder_pkg::OP_OR_FALL) |=>
      logic_result == ($past(drive_in) | $past(contact_fall)))
    else $error("falling contact term wrong");

  rise_pulse_a: assert property (@(posedge clock) disable iff (!resetn)
    pulse_rise_seen |=> bit_wr && (bit_val[0] == $past(rise)) && (bit_count == 2'h1))
    else $error("rising pulse bit wrong");

  fall_pulse_a: assert property (@(posedge clock) disable iff (!resetn)
    exec_valid && (exec_op == ladder_pkg::OP_FALL_PULSE) && fall |=>
      bit_wr && bit_val[0] ##0 (hist_q[$past(edge_slot)] == 1'b0))
    else $error("falling pulse bit wrong");

  scan_wrap_a: assert property (@(posedge clock) disable iff (!resetn)
    exec_valid && (exec_op == ladder_pkg::OP_END) |=> scan_wrap && (prog_addr == 16'h0000))
    else $error("scan did not restart at zero");

  cmp_onehot_a: assert property (@(posedge clock) disable iff (!resetn)
    cmp_driven |=> bit_wr && $onehot(bit_val) && (bit_count == 2'h3))
    else $error("compare result not one-hot");

  cmp_sign_a: assert property (@(posedge clock) disable iff (!resetn)
    cmp_driven ##0 (b_neg && !a_neg) |=> bit_val == 3'h1)
    else $error("signed compare ordering wrong");

  idle_hold_a: assert property (@(posedge clock) disable iff (!resetn)
    exec_valid && !drive_in && ((exec_op == ladder_pkg::OP_COMPARE) ||
      (exec_op == ladder_pkg::OP_ZONE)) |=> !bit_wr)
    else $error("idle compare wrote results");

  zone_swap_a: assert property (@(posedge clock) disable iff (!resetn)
    zone_driven ##0 bounds_swapped ##0 (val_c == val_a) |=> bit_val == 3'h2)
    else $error("swapped bounds not collapsed");

  step_adv_a: assert property (@(posedge clock) disable iff (!resetn)
    exec_valid && (exec_op == ladder_pkg::OP_ZONE) |=>
      prog_addr == 16'($past(prog_addr) + 16'h0009))
    else $error("zone step length wrong");

  copy_move_a: assert property (@(posedge clock) disable iff (!resetn)
    exec_valid && (exec_op == ladder_pkg::OP_COPY) && !drive_in |=> !word_wr
      ##0 $stable(word_data))
    else $error("idle copy changed destination");

  pulse_once_a: assert property (@(posedge clock) disable iff (!resetn)
    exec_valid && is_app && exec_pulse && drive_in && hist |=> !bit_wr && !word_wr)
    else $error("pulse form fired twice");

endmodule // ladder_edge_compare_exec
`default_nettype wire

// ### shared/ladder_pkg.sv
`default_nettype none
package ladder_pkg;

  // ----------------------------------------------------------------
  // instruction codes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_IDLE       = 3'h0,
    OP_OR_FALL    = 3'h1,
    OP_RISE_PULSE = 3'h2,
    OP_FALL_PULSE = 3'h3,
    OP_COMPARE    = 3'h4,
    OP_ZONE       = 3'h5,
    OP_COPY       = 3'h6,
    OP_END        = 3'h7
  } op_t;

  // ----------------------------------------------------------------
  // sizes, lengths and result codes
  // ----------------------------------------------------------------
  localparam int          SLOT_W     = 6;
  localparam int          SLOTS      = 64;
  localparam int          PC_W       = 16;
  localparam int          DEV_W      = 8;
  localparam int          SIGN_NARROW = 15;
  localparam int          SIGN_WIDE  = 31;
  localparam logic [15:0] PC_START   = 16'h0000;
  localparam logic [3:0]  STEP_BASIC = 4'h1;
  localparam logic [3:0]  STEP_CMP   = 4'h7;
  localparam logic [3:0]  STEP_ZONE  = 4'h9;
  localparam logic [3:0]  STEP_COPY  = 4'h5;
  localparam logic [1:0]  CNT_ONE    = 2'h1;
  localparam logic [1:0]  CNT_TRIPLE = 2'h3;
  localparam logic [2:0]  RES_FIRST  = 3'h1;
  localparam logic [2:0]  RES_SECOND = 3'h2;
  localparam logic [2:0]  RES_THIRD  = 3'h4;

  // sign-extend the narrow form so one comparator serves both widths
  function automatic logic signed [31:0] widen(input logic [31:0] v,
                                               input logic        wide);
    widen = wide ? v : {{16{v[SIGN_NARROW]}}, v[15:0]};
  endfunction

  function automatic logic [3:0] step_len(input op_t op);
    case (op)
      OP_COMPARE: step_len = STEP_CMP;
      OP_ZONE:    step_len = STEP_ZONE;
      OP_COPY:    step_len = STEP_COPY;
      default:    step_len = STEP_BASIC;
    endcase
  endfunction

endpackage
`default_nettype wire

// ### shared/cmp_if.sv
`timescale 1ns/1ps
`default_nettype none
interface cmp_if;
  logic        wide;
  logic [31:0] val_a;
  logic [31:0] val_b;
  logic [31:0] val_c;
  logic [2:0]  cmp_res;
  logic [2:0]  zone_res;
  modport unit (input wide, val_a, val_b, val_c, output cmp_res, zone_res);
  modport user (output wide, val_a, val_b, val_c, input cmp_res, zone_res);
endinterface
`default_nettype wire

// ### hw/compare_unit.sv
`timescale 1ns/1ps
`default_nettype none
module compare_unit (
  cmp_if.unit cif
);

  // ----------------------------------------------------------------
  // signed comparators
  // ----------------------------------------------------------------
  logic signed [31:0] sa;
  logic signed [31:0] sb;
  logic signed [31:0] sc;
  logic signed [31:0] upper;

  always_comb begin
    sa = ladder_pkg::widen(cif.val_a, cif.wide);
    sb = ladder_pkg::widen(cif.val_b, cif.wide);
    sc = ladder_pkg::widen(cif.val_c, cif.wide);
    // a bad bound pair collapses the zone to one point, never inverts it
    upper = (sa > sb) ? sa : sb;
    if (sa > sb) begin
      cif.cmp_res = ladder_pkg::RES_FIRST;
    end else if (sa == sb) begin
      cif.cmp_res = ladder_pkg::RES_SECOND;
    end else begin
      cif.cmp_res = ladder_pkg::RES_THIRD;
    end
    if (sc < sa) begin
      cif.zone_res = ladder_pkg::RES_FIRST;
    end else if (sc > upper) begin
      cif.zone_res = ladder_pkg::RES_THIRD;
    end else begin
      cif.zone_res = ladder_pkg::RES_SECOND;
    end
  end

endmodule // compare_unit
`default_nettype wire

// ### hw/unused_placeholder_none.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ### tb/tb_ladder_edge_compare_exec.sv
`timescale 1ns/1ps
`default_nettype none
module tb_ladder_edge_compare_exec;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic            clock;
  logic            resetn;
  logic            exec_valid;
  ladder_pkg::op_t exec_op;
  logic            exec_pulse;
  logic            exec_wide;
  logic            drive_in;
  logic            contact_in;
  logic [5:0]      edge_slot;
  logic [7:0]      dest_dev;
  logic [31:0]     val_a;
  logic [31:0]     val_b;
  logic [31:0]     val_c;
  logic            logic_result;
  logic            bit_wr;
  logic [7:0]      bit_addr;
  logic [1:0]      bit_count;
  logic [2:0]      bit_val;
  logic            word_wr;
  logic [7:0]      word_addr;
  logic [31:0]     word_data;
  logic [15:0]     prog_addr;
  logic            scan_wrap;
  logic [15:0]     pc_exp;
  int              err_total;
  int              checked;

  ladder_edge_compare_exec uut (
    .clock(clock), .resetn(resetn), .exec_valid(exec_valid), .exec_op(exec_op),
    .exec_pulse(exec_pulse), .exec_wide(exec_wide), .drive_in(drive_in),
    .contact_in(contact_in), .edge_slot(edge_slot), .dest_dev(dest_dev),
    .val_a(val_a), .val_b(val_b), .val_c(val_c), .logic_result(logic_result),
    .bit_wr(bit_wr), .bit_addr(bit_addr), .bit_count(bit_count), .bit_val(bit_val),
    .word_wr(word_wr), .word_addr(word_addr), .word_data(word_data),
    .prog_addr(prog_addr), .scan_wrap(scan_wrap)
  );

  always #20 clock = ~clock;

  // ----------------------------------------------------------------
  // checking helpers
  // ----------------------------------------------------------------
  task automatic chk_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_bits(input logic wr, input logic [7:0] a, input logic [1:0] n,
                          input logic [2:0] v);
    chk_bit(bit_wr, wr);
    // a refused write must leave the previous result bits standing
    chk_word({29'h0, bit_val}, {29'h0, v});
    if (wr) begin
      chk_word({24'h0, bit_addr}, {24'h0, a});
      chk_word({30'h0, bit_count}, {30'h0, n});
    end
  endtask

  function automatic logic [3:0] len_of(input ladder_pkg::op_t op);
    if (op == ladder_pkg::OP_COMPARE) return ladder_pkg::STEP_CMP;
    if (op == ladder_pkg::OP_ZONE) return ladder_pkg::STEP_ZONE;
    if (op == ladder_pkg::OP_COPY) return ladder_pkg::STEP_COPY;
    return ladder_pkg::STEP_BASIC;
  endfunction

  // one instruction per call; operands are set by the caller beforehand
  task automatic go(input ladder_pkg::op_t op);
    exec_op    = op;
    exec_valid = 1'b1;
    @(posedge clock);
    #1;
    if (op == ladder_pkg::OP_END) pc_exp = ladder_pkg::PC_START;
    else pc_exp = pc_exp + {12'h000, len_of(op)};
    chk_word({16'h0, prog_addr}, {16'h0, pc_exp});
    chk_bit(scan_wrap, op == ladder_pkg::OP_END);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    chk_word({bit_wr, word_wr, logic_result, scan_wrap, 12'h0, prog_addr}, 32'h0);
  endtask

  task automatic t_compare();
    logic [31:0] a [6] = '{32'h5, 32'h3, 32'hfffe, 32'h80000000, 32'hffff0003, 32'h7fff};
    logic [31:0] b [6] = '{32'h3, 32'h3, 32'h1, 32'h0, 32'h2, 32'h8000};
    logic [2:0]  e [6] = '{3'h1, 3'h2, 3'h4, 3'h4, 3'h1, 3'h1};
    for (int i = 0; i < 6; i++) begin
      val_a     = a[i];
      val_b     = b[i];
      exec_wide = (i == 3);
      drive_in  = 1'b1;
      dest_dev  = 8'h10 + 8'(i);
      go(ladder_pkg::OP_COMPARE);
      chk_bits(1'b1, dest_dev, 2'h3, e[i]);
    end
    // these operands would give the less-than code if evaluated
    val_a    = 32'h1;
    val_b    = 32'h5;
    drive_in = 1'b0;
    go(ladder_pkg::OP_COMPARE);
    chk_bits(1'b0, 8'h15, ladder_pkg::CNT_TRIPLE, 3'h1);
  endtask

  task automatic t_zone();
    logic [31:0] lo [9] = '{32'd10, 32'd10, 32'd10, 32'd10, 32'd10, 32'd50, 32'd50, 32'd50,
                            32'hfffffff0};
    logic [31:0] hi [9] = '{32'd100, 32'd100, 32'd100, 32'd100, 32'd100, 32'd20, 32'd20,
                            32'd20, 32'd10};
    logic [31:0] v [9]  = '{32'd5, 32'd10, 32'd100, 32'd101, 32'hffff, 32'd50, 32'd49,
                            32'd51, 32'hffffffff};
    logic [2:0]  e [9]  = '{3'h1, 3'h2, 3'h2, 3'h4, 3'h1, 3'h2, 3'h1, 3'h4, 3'h2};
    for (int i = 0; i < 9; i++) begin
      val_a     = lo[i];
      val_b     = hi[i];
      val_c     = v[i];
      exec_wide = (i == 8);
      drive_in  = 1'b1;
      dest_dev  = 8'h40;
      go(ladder_pkg::OP_ZONE);
      chk_bits(1'b1, 8'h40, 2'h3, e[i]);
    end
    // above the zone: would give the above code if evaluated
    val_c    = 32'd100;
    drive_in = 1'b0;
    go(ladder_pkg::OP_ZONE);
    chk_bits(1'b0, 8'h40, ladder_pkg::CNT_TRIPLE, 3'h2);
  endtask

  task automatic t_copy();
    exec_wide = 1'b1;
    val_a     = 32'h12345678;
    dest_dev  = 8'h20;
    drive_in  = 1'b1;
    go(ladder_pkg::OP_COPY);
    chk_word({word_wr, 15'h0, 8'h0, word_addr}, {1'b1, 23'h0, 8'h20});
    chk_word(word_data, 32'h12345678);
    val_a    = 32'hcafe0001;
    drive_in = 1'b0;
    go(ladder_pkg::OP_COPY);
    chk_bit(word_wr, 1'b0);
    chk_word(word_data, 32'h12345678);
  endtask

  // drives and expected bits are taken from bit 0 upward, one scan each
  task automatic t_pulse(input ladder_pkg::op_t op, input logic [5:0] slot,
                         input logic [3:0] drv, input logic [3:0] exp);
    for (int i = 0; i < 4; i++) begin
      drive_in  = drv[i];
      edge_slot = slot;
      dest_dev  = 8'h30 + 8'(slot);
      go(op);
      chk_bits(1'b1, dest_dev, 2'h1, {2'b00, exp[i]});
      go(ladder_pkg::OP_END);
    end
  endtask

  task automatic t_or_fall();
    logic [5:0] con = 6'b010011;
    logic [5:0] e   = 6'b100100;
    edge_slot = 6'd5;
    drive_in  = 1'b0;
    for (int i = 0; i < 6; i++) begin
      contact_in = con[i];
      go(ladder_pkg::OP_OR_FALL);
      chk_bit(logic_result, e[i]);
      go(ladder_pkg::OP_END);
    end
    drive_in   = 1'b1;
    contact_in = 1'b1;
    go(ladder_pkg::OP_OR_FALL);
    chk_bit(logic_result, 1'b1);
  endtask

  // pulse forms act on the off-to-on scan only; history moves with drive
  task automatic t_pulse_form();
    logic [4:0] drv = 5'b10110;
    logic [4:0] e   = 5'b10010;
    exec_pulse = 1'b1;
    exec_wide  = 1'b0;
    val_a      = 32'h2;
    val_b      = 32'h9;
    dest_dev   = 8'h50;
    for (int i = 0; i < 5; i++) begin
      drive_in  = drv[i];
      edge_slot = 6'd6;
      go(ladder_pkg::OP_COMPARE);
      chk_bit(bit_wr, e[i]);
      edge_slot = 6'd7;
      go(ladder_pkg::OP_COPY);
      chk_bit(word_wr, e[i]);
    end
    exec_pulse = 1'b0;
    exec_valid = 1'b0;
  endtask

  // ----------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------
  task automatic complete_run();
    if (err_total == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    #(5000 * 40);
    err_total++;
    complete_run();
  end

  initial begin
    {clock, resetn, exec_valid, exec_pulse, exec_wide, drive_in, contact_in} = 7'h0;
    exec_op   = ladder_pkg::OP_IDLE;
    edge_slot = 6'h00;
    dest_dev  = 8'h00;
    {val_a, val_b, val_c} = 96'h0;
    pc_exp    = ladder_pkg::PC_START;
    err_total = 0;
    checked   = 0;
    repeat (8) @(posedge clock);
    #1;
    resetn = 1'b1;
    t_reset();
    go(ladder_pkg::OP_IDLE);
    t_compare();
    t_zone();
    t_copy();
    t_pulse(ladder_pkg::OP_RISE_PULSE, 6'd3, 4'b0110, 4'b0010);
    t_pulse(ladder_pkg::OP_FALL_PULSE, 6'd4, 4'b0011, 4'b0100);
    t_or_fall();
    t_pulse_form();
    complete_run();
  end
endmodule // tb_ladder_edge_compare_exec
`default_nettype wire
